// >>> core/nmic_top.sv
// Interrupt controller with non-maskable and maskable entry and return
`timescale 1ns/1ns
`include "nmic_map.svh"
module nmic_top (
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst_b,
   // Register port
   input  wire logic [`NMIC_ADDR_W-1:0]  reg_addr,
   input  wire logic [31:0]              reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [31:0]              reg_rdata,
   // Event sources
   input  wire logic [`NMIC_NSRC-1:0]    src_req,
   input  wire logic                     wdt_ovf,
   // Core side
   input  wire logic [31:0]              pc_now,
   input  wire logic                     return_from_interrupt_instr_exec,
   input  wire logic                     ei_exec,
   input  wire logic                     di_exec,
   output logic                          pc_load,
   output logic      [31:0]              pc_target,
   output logic      [31:0]              psw_out
);
   // Reset synchroniser; only the second stage is used
   logic [1:0] rst_sync_r;
   logic       rst_n;

   // Core-state registers and their next values
   logic [31:0] psw_r, psw_nxt;         // Program status word
   logic [31:0] maskable_saved_pc_r, maskable_saved_pc_nxt;       // Maskable saved PC
   logic [31:0] maskable_saved_status_r, maskable_saved_status_nxt;     // Maskable saved status
   logic [31:0] nmi_saved_pc_r, nmi_saved_pc_nxt;       // NMI saved PC
   logic [31:0] nmi_saved_status_r, nmi_saved_status_nxt;     // NMI saved status
   logic [31:0] ecr_r, ecr_nxt;         // Exception cause
   logic [7:0]  in_service_level_reg_r, in_service_level_reg_nxt;       // In-service levels
   logic [1:0]  wdm_r, wdm_nxt;         // Watchdog mode bits
   logic        nmi_pend_r, nmi_pend_nxt;
   logic        pc_load_r, pc_load_nxt;
   logic [31:0] pc_tgt_r, pc_tgt_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // Decode helpers
   logic                   ic_hit;      // Address lands on a control register
   logic [`NMIC_ADDR_W-1:0] ic_off;
   logic [`NMIC_IDX_W-1:0] ic_idx;
   logic [3:0]             svc_lvl;     // Best level in service
   logic [2:0]             ret_bit;     // In-service bit freed by a return
   nmic_pkg::nmic_evt_e    evt;
   logic                   np_now;
   logic                   id_now;
   logic                   ep_now;

   // Bundle shared with the register bank and the arbiter
   nmic_src_if sif ();

   // Release reset through two flops
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Control register bank
   nmic_ctl_regs u_regs (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .src_req (src_req),
      .sif     (sif.regs)
   );

   // Priority arbiter
   nmic_arb u_arb (
      .sif (sif.arb)
   );

   // Control register address decode: one register every two bytes
   // Odd addresses fall between control registers and are refused
   assign ic_off = reg_addr - `NMIC_IC_FIRST;
   assign ic_hit = (reg_addr >= `NMIC_IC_FIRST) && (reg_addr <= `NMIC_IC_LAST) &&
                   !reg_addr[0];
   assign ic_idx = ic_off[`NMIC_IDX_W:1];

   // Status flags that gate the acceptance and return decisions
   assign np_now = psw_r[`NMIC_PSW_NP];
   assign id_now = psw_r[`NMIC_PSW_ID];
   assign ep_now = psw_r[`NMIC_PSW_EP];

   // Highest level in service is the lowest set bit; also the one a return frees
   always_comb begin
      svc_lvl = `NMIC_LVL_NONE;
      ret_bit = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (in_service_level_reg_r[i]) begin
            svc_lvl = 4'(i);
            ret_bit = 3'(i);
         end
      end
   end

   // Event choice: a return first, then NMI, then the presented maskable winner
   // A return is never delayed, so a burst of requests cannot starve a handler
   always_comb begin
      if (return_from_interrupt_instr_exec) begin
         evt = nmic_pkg::EV_RET;
      end else if (nmi_pend_r && !np_now) begin
         evt = nmic_pkg::EV_NMI;
      end else if (sif.win_valid && !id_now && !np_now) begin
         evt = nmic_pkg::EV_MASK;
      end else begin
         evt = nmic_pkg::EV_NONE; // Requests simply stay pending
      end
   end

   // Bundle drive: byte writes and acceptance clear
   assign sif.svc_lvl = svc_lvl;
   assign sif.wr_en   = reg_wr && ic_hit;
   assign sif.wr_idx  = ic_idx;
   assign sif.wr_data = reg_wdata[7:0];
   assign sif.ack_en  = (evt == nmic_pkg::EV_MASK);
   assign sif.ack_idx = sif.win_idx;

   // Next core state: software loads, instructions, then the chosen event
   always_comb begin
      psw_nxt      = psw_r;
      maskable_saved_pc_nxt     = maskable_saved_pc_r;
      maskable_saved_status_nxt    = maskable_saved_status_r;
      nmi_saved_pc_nxt     = nmi_saved_pc_r;
      nmi_saved_status_nxt    = nmi_saved_status_r;
      ecr_nxt      = ecr_r;
      in_service_level_reg_nxt     = in_service_level_reg_r;
      wdm_nxt      = wdm_r;
      nmi_pend_nxt = nmi_pend_r;
      pc_load_nxt  = 1'b0;
      pc_tgt_nxt   = pc_tgt_r;
      // Software loads of core-side registers
      if (reg_wr) begin
         unique case (reg_addr)
            `NMIC_A_PSW:   psw_nxt   = reg_wdata; // Clearing ID or NP frees pending
            `NMIC_A_MASKABLE_SAVED_PC:  maskable_saved_pc_nxt  = reg_wdata;
            `NMIC_A_MASKABLE_SAVED_STATUS: maskable_saved_status_nxt = reg_wdata;
            `NMIC_A_NMI_SAVED_PC:  nmi_saved_pc_nxt  = reg_wdata;
            `NMIC_A_NMI_SAVED_STATUS: nmi_saved_status_nxt = reg_wdata;
            `NMIC_A_ECR:   ecr_nxt   = reg_wdata;
            `NMIC_A_WDM:   wdm_nxt   = reg_wdata[1:0];
            default: begin
               // Control registers and unmapped writes change nothing here
            end
         endcase
      end
      // Enable and disable instructions
      if (ei_exec) begin
         psw_nxt[`NMIC_PSW_ID] = 1'b0;
      end
      if (di_exec) begin
         psw_nxt[`NMIC_PSW_ID] = 1'b1;
      end
      // The chosen event
      // Events come last so their fields win over a same-cycle register load
      unique case (evt)
         nmic_pkg::EV_NMI: begin
            // Save the interrupted context first, then enter the handler
            nmi_saved_pc_nxt                 = pc_now;
            nmi_saved_status_nxt                = psw_r;
            ecr_nxt[31:16]           = `NMIC_NMI_CODE;
            psw_nxt[`NMIC_PSW_NP]    = 1'b1;
            psw_nxt[`NMIC_PSW_ID]    = 1'b1;
            psw_nxt[`NMIC_PSW_EP]    = 1'b0;
            pc_load_nxt              = 1'b1;
            pc_tgt_nxt               = `NMIC_NMI_VEC;
            nmi_pend_nxt             = 1'b0;
         end
         nmic_pkg::EV_MASK: begin
            // The in-service bit holds off equal and lower levels until return
            maskable_saved_pc_nxt                 = pc_now;
            maskable_saved_status_nxt                = psw_r;
            ecr_nxt[15:0]            = 16'(`NMIC_MI_BASE + {sif.win_idx, 4'h0});
            psw_nxt[`NMIC_PSW_ID]    = 1'b1;
            psw_nxt[`NMIC_PSW_EP]    = 1'b0;
            in_service_level_reg_nxt[sif.win_lvl]    = 1'b1;
            pc_load_nxt              = 1'b1;
            pc_tgt_nxt               = `NMIC_MI_BASE + {22'h0, sif.win_idx, 4'h0};
         end
         nmic_pkg::EV_RET: begin
            if (!ep_now && np_now) begin
               // Non-maskable return leaves the in-service levels untouched
               pc_tgt_nxt  = nmi_saved_pc_r;
               psw_nxt     = nmi_saved_status_r;
               pc_load_nxt = 1'b1;
            end else if (!ep_now && !np_now) begin
               pc_tgt_nxt  = maskable_saved_pc_r;
               psw_nxt     = maskable_saved_status_r;
               pc_load_nxt = 1'b1;
               in_service_level_reg_nxt[ret_bit] = 1'b0;
            end else begin
               // Exception return lies outside this block; IN_SERVICE_LEVEL_REG kept
               pc_load_nxt = 1'b0;
            end
         end
         nmic_pkg::EV_NONE: begin
            pc_load_nxt = 1'b0;
         end
      endcase
      // Watchdog overflow raises NMI only in the NMI mode; set beats clear
      // Several overflows while one is pending collapse into a single request
      if (wdt_ovf && wdm_r == `NMIC_WDM_NMI) begin
         nmi_pend_nxt = 1'b1;
      end
   end

   // Read data for the cycle after a read strobe; unmapped reads give zero
   // Zero outside that cycle lets several slaves share one combined read bus
   always_comb begin
      rdata_nxt = 32'h0;
      if (reg_rd) begin
         if (ic_hit) begin
            // Flag read may race an acceptance; software disables first
            rdata_nxt[7:0] = {sif.req_flag[ic_idx], sif.mask[ic_idx], 3'h0,
                              sif.prio[ic_idx]};
         end else begin
            unique case (reg_addr)
               `NMIC_A_PSW:   rdata_nxt = psw_r;
               `NMIC_A_MASKABLE_SAVED_PC:  rdata_nxt = maskable_saved_pc_r;
               `NMIC_A_MASKABLE_SAVED_STATUS: rdata_nxt = maskable_saved_status_r;
               `NMIC_A_NMI_SAVED_PC:  rdata_nxt = nmi_saved_pc_r;
               `NMIC_A_NMI_SAVED_STATUS: rdata_nxt = nmi_saved_status_r;
               `NMIC_A_ECR:   rdata_nxt = ecr_r;
               `NMIC_A_IN_SERVICE_LEVEL_REG:  rdata_nxt = {24'h0, in_service_level_reg_r};
               `NMIC_A_WDM:   rdata_nxt = {30'h0, wdm_r};
               default:       rdata_nxt = 32'h0;
            endcase
         end
      end
   end

   // Register all core-side state
   // Every element uses the synchronised reset, so all leave reset together
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         psw_r      <= `NMIC_PSW_RST;
         maskable_saved_pc_r     <= 32'h0;
         maskable_saved_status_r    <= 32'h0;
         nmi_saved_pc_r     <= 32'h0;
         nmi_saved_status_r    <= 32'h0;
         ecr_r      <= 32'h0;
         in_service_level_reg_r     <= 8'h0;
         wdm_r      <= `NMIC_WDM_RST;
         nmi_pend_r <= 1'b0;
         pc_load_r  <= 1'b0;
         pc_tgt_r   <= 32'h0;
         rdata_r    <= 32'h0;
      end else begin
         psw_r      <= psw_nxt;
         maskable_saved_pc_r     <= maskable_saved_pc_nxt;
         maskable_saved_status_r    <= maskable_saved_status_nxt;
         nmi_saved_pc_r     <= nmi_saved_pc_nxt;
         nmi_saved_status_r    <= nmi_saved_status_nxt;
         ecr_r      <= ecr_nxt;
         in_service_level_reg_r     <= in_service_level_reg_nxt;
         wdm_r      <= wdm_nxt;
         nmi_pend_r <= nmi_pend_nxt;
         pc_load_r  <= pc_load_nxt;
         pc_tgt_r   <= pc_tgt_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   // Outputs straight from flops
   assign reg_rdata = rdata_r;
   assign pc_load   = pc_load_r;
   assign pc_target = pc_tgt_r;
   assign psw_out   = psw_r;
endmodule

// >>> core/nmic_map.svh
// Register offsets, field positions, reset values and codes of the interrupt controller
`ifndef NMIC_MAP_SVH
`define NMIC_MAP_SVH
`define NMIC_NSRC     60
`define NMIC_IDX_W    6
`define NMIC_ADDR_W   12
`define NMIC_A_PSW    12'h010
`define NMIC_A_MASKABLE_SAVED_PC   12'h020
`define NMIC_A_MASKABLE_SAVED_STATUS  12'h024
`define NMIC_A_NMI_SAVED_PC   12'h028
`define NMIC_A_NMI_SAVED_STATUS  12'h02C
`define NMIC_A_ECR    12'h030
`define NMIC_A_IN_SERVICE_LEVEL_REG   12'h034
`define NMIC_A_WDM    12'h038
`define NMIC_IC_FIRST 12'h110
`define NMIC_IC_LAST  12'h186
`define NMIC_IC_RST   8'h47
`define NMIC_IC_IF    7
`define NMIC_IC_MK    6
`define NMIC_PSW_RST  32'h00000020
`define NMIC_PSW_ID   5
`define NMIC_PSW_EP   6
`define NMIC_PSW_NP   7
`define NMIC_NMI_CODE 16'h0010
`define NMIC_NMI_VEC  32'h00000010
`define NMIC_MI_BASE  32'h00000080
`define NMIC_WDM_NMI  2'h1
`define NMIC_WDM_RST  2'h0
`define NMIC_LVL_NONE 4'h8
`endif

// >>> core/nmic_pkg.sv
// Types shared by the interrupt controller modules
package nmic_pkg;
   // Event taken by the core in one cycle
   typedef enum logic [1:0] {
      EV_NONE = 2'b00,
      EV_NMI  = 2'b01,
      EV_MASK = 2'b10,
      EV_RET  = 2'b11
   } nmic_evt_e;
   typedef logic [2:0] nmic_lvl_t;
endpackage

// >>> core/nmic_src_if.sv
// Bundle between the top, the control register bank and the arbiter
`timescale 1ns/1ns
`include "nmic_map.svh"
interface nmic_src_if;
   logic [`NMIC_NSRC-1:0]                 req_flag;  // Request flags
   logic [`NMIC_NSRC-1:0]                 mask;      // Mask bits, 1 holds pending
   nmic_pkg::nmic_lvl_t [`NMIC_NSRC-1:0]  prio;      // Programmable levels
   logic [3:0]                            svc_lvl;   // Best level in service, 8 = none
   logic                                  win_valid; // A request may be presented
   logic [`NMIC_IDX_W-1:0]                win_idx;   // Winning source
   nmic_pkg::nmic_lvl_t                   win_lvl;   // Winner's level
   logic                                  wr_en;     // Byte write to one control reg
   logic [`NMIC_IDX_W-1:0]                wr_idx;
   logic [7:0]                            wr_data;
   logic                                  ack_en;    // Winner accepted this cycle
   logic [`NMIC_IDX_W-1:0]                ack_idx;
   modport top (input req_flag, mask, prio, win_valid, win_idx, win_lvl,
                output svc_lvl, wr_en, wr_idx, wr_data, ack_en, ack_idx);
   modport regs (output req_flag, mask, prio,
                 input wr_en, wr_idx, wr_data, ack_en, ack_idx);
   modport arb (input req_flag, mask, prio, svc_lvl,
                output win_valid, win_idx, win_lvl);
endinterface

// >>> core/nmic_ctl_regs.sv
// Bank of per-source interrupt control registers
`timescale 1ns/1ns
`include "nmic_map.svh"
module nmic_ctl_regs (
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   // Request pulses from peripherals
   input  wire logic [`NMIC_NSRC-1:0] src_req,
   // Shared bundle
   nmic_src_if.regs                 sif
);
   genvar g;
   generate
      for (g = 0; g < `NMIC_NSRC; g++) begin : g_src
         logic [7:0] ic_r;
         logic [7:0] ic_nxt;
         // Next value: software byte write, acceptance clear, then peripheral set
         always_comb begin
            ic_nxt = ic_r;
            if (sif.wr_en && sif.wr_idx == `NMIC_IDX_W'(g)) begin
               ic_nxt = {sif.wr_data[7:6], 3'h0, sif.wr_data[2:0]};
            end
            if (sif.ack_en && sif.ack_idx == `NMIC_IDX_W'(g)) begin
               ic_nxt[`NMIC_IC_IF] = 1'b0;
            end
            // A new request beats a clear in the same cycle
            if (src_req[g]) begin
               ic_nxt[`NMIC_IC_IF] = 1'b1;
            end
         end
         // Storage
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               ic_r <= `NMIC_IC_RST;
            end else begin
               ic_r <= ic_nxt;
            end
         end
         assign sif.req_flag[g] = ic_r[`NMIC_IC_IF];
         assign sif.mask[g]     = ic_r[`NMIC_IC_MK];
         assign sif.prio[g]     = ic_r[2:0];
      end
   endgenerate
endmodule

// >>> core/nmic_arb.sv
// Single-cycle arbiter over the pending unmasked requests
`timescale 1ns/1ns
`include "nmic_map.svh"
module nmic_arb (
   // Shared bundle
   nmic_src_if.arb sif
);
   logic                   found;
   logic [`NMIC_IDX_W-1:0] best_idx;
   nmic_pkg::nmic_lvl_t    best_lvl;
   // Lowest level wins; strict compare keeps the lower default number on a tie
   always_comb begin
      found    = 1'b0;
      best_idx = '0;
      best_lvl = 3'h7;
      for (int i = 0; i < `NMIC_NSRC; i++) begin
         if (sif.req_flag[i] && !sif.mask[i] &&
             (!found || sif.prio[i] < best_lvl)) begin
            found    = 1'b1;
            best_idx = `NMIC_IDX_W'(i);
            best_lvl = sif.prio[i];
         end
      end
   end
   // Only a level strictly above everything in service is presented
   assign sif.win_valid = found && ({1'b0, best_lvl} < sif.svc_lvl);
   assign sif.win_idx   = best_idx;
   assign sif.win_lvl   = best_lvl;
endmodule

// >>> verification/nmic_top_assertions.sv
// Port-level checker for the interrupt controller, bound into the top module
`timescale 1ns/1ns
`include "nmic_map.svh"
module nmic_top_chk (
   // Clock and reset
   input wire logic                    ref_clk,
   input wire logic                    rst_b,
   // Register port
   input wire logic [`NMIC_ADDR_W-1:0] reg_addr,
   input wire logic [31:0]             reg_wdata,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [31:0]             reg_rdata,
   // Events and core side
   input wire logic                    wdt_ovf,
   input wire logic                    return_from_interrupt_instr_exec,
   input wire logic                    pc_load,
   input wire logic [31:0]             pc_target,
   input wire logic [31:0]             psw_out
);
   logic [1:0] wdm_r;   // Shadow of the watchdog mode field
   logic [1:0] wdm_nxt; // Its next value

   // Track mode writes, since the field is not visible at the ports
   always_comb begin
      wdm_nxt = wdm_r;
      if (reg_wr && reg_addr == `NMIC_A_WDM) begin
         wdm_nxt = reg_wdata[1:0];
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wdm_r <= `NMIC_WDM_RST;
      end else begin
         wdm_r <= wdm_nxt;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_psw_reset_value: assert property (
      $rose(rst_b) |-> psw_out == `NMIC_PSW_RST)
      else $error("status word wrong after reset");
   a_nmi_entry_state: assert property (
      pc_load && psw_out[`NMIC_PSW_NP] && !$past(psw_out[`NMIC_PSW_NP])
      |-> pc_target == `NMIC_NMI_VEC && psw_out[`NMIC_PSW_ID] && !psw_out[`NMIC_PSW_EP])
      else $error("non-maskable entry state wrong");
   // An overflow with mode 01 must branch two cycles later, whatever the disable flag
   a_nmi_latency: assert property (
      wdt_ovf && wdm_r == `NMIC_WDM_NMI && !psw_out[`NMIC_PSW_NP]
      ##1 !return_from_interrupt_instr_exec && !psw_out[`NMIC_PSW_NP] |=> pc_load && pc_target == `NMIC_NMI_VEC)
      else $error("non-maskable request not taken in time");
   a_nmi_blocks_all: assert property (
      psw_out[`NMIC_PSW_NP] && !return_from_interrupt_instr_exec |=> !pc_load)
      else $error("branch taken while non-maskable service active");
   a_id_blocks_mask: assert property (
      psw_out[`NMIC_PSW_ID] && !psw_out[`NMIC_PSW_NP] && !return_from_interrupt_instr_exec
      |=> !pc_load || pc_target == `NMIC_NMI_VEC)
      else $error("maskable entry while interrupts disabled");
   a_mask_entry_state: assert property (
      pc_load && !$past(return_from_interrupt_instr_exec) && !psw_out[`NMIC_PSW_NP]
      |-> psw_out[`NMIC_PSW_ID] && !psw_out[`NMIC_PSW_EP] && pc_target[3:0] == 4'h0
          && pc_target >= `NMIC_MI_BASE && pc_target <= 32'h00000430)
      else $error("maskable entry state or vector wrong");
   a_return_branch: assert property (
      return_from_interrupt_instr_exec && !psw_out[`NMIC_PSW_EP] |=> pc_load)
      else $error("return did not branch");
   a_ctl_read_bits: assert property (
      reg_rd && reg_addr >= `NMIC_IC_FIRST && reg_addr <= `NMIC_IC_LAST
      |=> reg_rdata[31:8] == 24'h000000 && reg_rdata[5:3] == 3'h0)
      else $error("control register reads nonzero in unused bits");

   // Main scenarios reached
   c_nmi_taken: cover property (pc_load && pc_target == `NMIC_NMI_VEC);
   c_mask_taken: cover property (pc_load && !$past(return_from_interrupt_instr_exec) && !psw_out[`NMIC_PSW_NP]);
   c_return: cover property (return_from_interrupt_instr_exec ##1 pc_load);
endmodule

bind nmic_top nmic_top_chk u_chk (
   .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_ovf(wdt_ovf),
   .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec), .pc_load(pc_load), .pc_target(pc_target), .psw_out(psw_out)
);

// >>> verification/nmic_core_model.sv
// Behavioural core that follows branches and issues return and enable pulses
`timescale 1ns/1ns
module nmic_core_model (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // Branch requests from the controller
   input  wire logic        pc_load,
   input  wire logic [31:0] pc_target,
   // Instruction picked by the bench: 1 return, 2 enable, 3 disable
   input  wire logic [1:0]  cmd,
   // Core status towards the controller
   output logic      [31:0] pc_now,
   output logic             return_from_interrupt_instr_exec,
   output logic             ei_exec,
   output logic             di_exec
);
   logic [31:0] pc_r; // Restore point after the last branch taken

   // Restore point sits one word past the last branch, so saves are predictable
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_r <= 32'h00001000;
      end else if (pc_load) begin
         pc_r <= pc_target + 32'h00000004;
      end
   end
   // A branch not yet followed is already the point to come back to
   assign pc_now = pc_load ? (pc_target + 32'h00000004) : pc_r;
   // Handlers disable before a nested return and leave the status flags alone
   assign return_from_interrupt_instr_exec = (cmd == 2'h1);
   // Flags are read only while requests are disabled; masks are changed while enabled too
   assign ei_exec = (cmd == 2'h2);
   assign di_exec = (cmd == 2'h3);
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
`include "nmic_map.svh"
module tb_top;
   logic                    ref_clk, rst_b;      // Clock and active-low reset
   logic [`NMIC_ADDR_W-1:0] reg_addr;            // Register port
   logic [31:0]             reg_wdata, reg_rdata;
   logic                    reg_wr, reg_rd;
   logic [`NMIC_NSRC-1:0]   src_req;             // Peripheral pulses
   logic                    wdt_ovf;             // Watchdog overflow pulse
   logic [31:0]             pc_now, pc_target, psw_out;
   logic                    return_from_interrupt_instr_exec, ei_exec, di_exec, pc_load;
   logic [1:0]              cmd;                 // Instruction for the core model
   logic [31:0]             rdv;                 // Last value read back
   int                      failures, checks;

   // Half period of 50 ns gives 10 MHz
   always #50 ref_clk = ~ref_clk;

   nmic_top uut (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
      .wdt_ovf(wdt_ovf), .pc_now(pc_now), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec), .ei_exec(ei_exec),
      .di_exec(di_exec), .pc_load(pc_load), .pc_target(pc_target), .psw_out(psw_out));
   nmic_core_model u_core (
      .ref_clk(ref_clk), .rst_b(rst_b), .pc_load(pc_load), .pc_target(pc_target),
      .cmd(cmd), .pc_now(pc_now), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec), .ei_exec(ei_exec),
      .di_exec(di_exec));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("Counts: checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Bus cycles: one strobe cycle each, read data taken in the following cycle
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      rdv = reg_rdata;
   endtask
   // One-cycle pulses; both return at the edge that samples them
   task automatic core_op(input logic [1:0] c);
      @(posedge ref_clk);
      cmd <= c;
      @(posedge ref_clk);
      cmd <= 2'h0;
   endtask
   task automatic fire(input logic [59:0] s, input logic w);
      @(posedge ref_clk);
      src_req <= s;
      wdt_ovf <= w;
      @(posedge ref_clk);
      src_req <= 60'h000000000000000;
      wdt_ovf <= 1'b0;
   endtask
   // Bounded wait for a branch, then check where it goes and the new status word
   task automatic wait_load(input logic [31:0] tgt, input logic [31:0] program_status_word);
      int i;
      for (i = 0; i < 20; i++) begin
         #1;
         if (pc_load === 1'b1) begin
            break;
         end
         @(posedge ref_clk);
      end
      if (i == 20) begin
         chk({31'h00000000, pc_load}, 32'h00000001);
         close_out();
      end else begin
         chk(pc_target, tgt);
         chk(psw_out, program_status_word);
         @(posedge ref_clk);
      end
   endtask
   task automatic no_load(input int n);
      repeat (n) begin
         #1;
         chk({31'h00000000, pc_load}, 32'h00000000);
         @(posedge ref_clk);
      end
   endtask

   initial begin
      ref_clk = 1'b0; rst_b = 1'b0; reg_addr = 12'h000; reg_wdata = 32'h00000000;
      reg_wr = 1'b0; reg_rd = 1'b0; src_req = 60'h000000000000000; wdt_ovf = 1'b0;
      cmd = 2'h0; failures = 0; checks = 0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      // Reset values, read-only and unmapped places
      chk(psw_out, `NMIC_PSW_RST);
      rd(`NMIC_IC_FIRST);
      chk(rdv, 32'h00000047);
      rd(`NMIC_IC_LAST);
      chk(rdv, 32'h00000047);
      wr(`NMIC_A_IN_SERVICE_LEVEL_REG, 32'h000000FF);
      rd(`NMIC_A_IN_SERVICE_LEVEL_REG);
      chk(rdv, 32'h00000000);
      rd(12'h111);
      chk(rdv, 32'h00000000);
      $display("Test reset done");
      // Non-maskable: gated by mode, taken while disabled, blocks, returns
      fire(60'h000000000000000, 1'b1);
      no_load(4);
      wr(`NMIC_A_WDM, 32'h00000001);
      fire(60'h000000000000000, 1'b1);
      wait_load(`NMIC_NMI_VEC, 32'h000000A0);
      rd(`NMIC_A_ECR);
      chk(rdv, 32'h00100000);
      rd(`NMIC_A_NMI_SAVED_PC);
      chk(rdv, 32'h00001000);
      rd(`NMIC_A_NMI_SAVED_STATUS);
      chk(rdv, 32'h00000020);
      fire(60'h000000000000001, 1'b1);
      no_load(4);
      core_op(2'h1);
      wait_load(32'h00001000, 32'h00000020);
      wait_load(`NMIC_NMI_VEC, 32'h000000A0);
      core_op(2'h1);
      wait_load(32'h00001004, 32'h00000020);
      $display("Test non-maskable done");
      // Maskable: pending, arbitration, nesting, return order
      wr(12'h116, 32'h00000002);
      wr(12'h11A, 32'h00000002);
      wr(12'h11E, 32'h00000041);
      fire(60'h0000000000000A8, 1'b0);
      no_load(3);
      rd(12'h116);
      chk(rdv, 32'h00000082);
      core_op(2'h2);
      wait_load(32'h000000B0, 32'h00000020);
      rd(`NMIC_A_ECR);
      chk(rdv, 32'h001000B0);
      rd(12'h116);
      chk(rdv, 32'h00000002);
      rd(`NMIC_A_IN_SERVICE_LEVEL_REG);
      chk(rdv, 32'h00000004);
      core_op(2'h2);
      no_load(4);
      wr(12'h11E, 32'h00000081);
      wait_load(32'h000000F0, 32'h00000020);
      rd(`NMIC_A_IN_SERVICE_LEVEL_REG);
      chk(rdv, 32'h00000006);
      core_op(2'h1);
      wait_load(32'h000000B4, 32'h00000000);
      rd(`NMIC_A_IN_SERVICE_LEVEL_REG);
      chk(rdv, 32'h00000004);
      core_op(2'h3);
      core_op(2'h1);
      wait_load(32'h000000B4, 32'h00000000);
      wait_load(32'h000000D0, 32'h00000020);
      $display("Test maskable done");
      // Software loads: exception return ignored, return from a loaded save, top source
      wr(`NMIC_A_PSW, 32'h00000040);
      core_op(2'h1);
      no_load(3);
      rd(`NMIC_A_IN_SERVICE_LEVEL_REG);
      chk(rdv, 32'h00000004);
      wr(`NMIC_A_MASKABLE_SAVED_PC, 32'h00001234);
      wr(`NMIC_A_PSW, 32'h00000000);
      core_op(2'h1);
      wait_load(32'h00001234, 32'h00000000);
      wr(`NMIC_IC_LAST, 32'h00000000);
      fire(60'h800000000000000, 1'b0);
      wait_load(32'h00000430, 32'h00000020);
      $display("Test software loads done");
      close_out();
   end
endmodule
